// file: inc/ihc_pkg.sv
// Purpose: shared constants and types of the command handler
// Assumes: one parallel cpu per handler, four parallel cpus in all
// Notes:   bit positions are defaults; the top makes them parameters
package ihc_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_CPU = 4;
    localparam int ID_W = 2;
    localparam int WORD_W = 32;
    localparam int SLOT_W = 2;
    localparam logic [SLOT_W-1:0] DELAY_SLOTS = 2'h2;

    // ----------------------------------------------------------------
    // command word layout (defaults)
    // ----------------------------------------------------------------
    localparam int BIT_DES_LSB = 0;   // parallel_cpu designators, one per cpu
    localparam int BIT_DES_MST = 4;   // master_cpu designator
    localparam int BIT_RST = 16;      // software reset
    localparam int BIT_HALT = 17;
    localparam int BIT_UNHALT = 18;
    localparam int BIT_ICLR = 19;     // instruction-cache reset
    localparam int BIT_TASK = 20;     // task interrupt
    localparam int BIT_MSG = 21;      // message interrupt
    localparam int BIT_DCLR = 22;     // data-cache reset
    localparam int BIT_VIDEO = 23;    // video_ctrl operation
    localparam int BIT_XFER = 24;     // transfer_ctrl operation

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic HALT_RST = 1'b1;      // hardware reset leaves cpu halted
    localparam logic VEC_PEND_RST = 1'b1;  // first unhalt starts at task vector

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] word;
    } ihc_cmd_s;

    typedef enum logic [1:0] {
        SLOT_IDLE,
        SLOT_EXEC,
        SLOT_WAIT
    } ihc_slot_e;

    typedef struct packed {
        logic task_req;
        logic mst_msg_req;
        logic [NUM_CPU-1:0] peer_msg_req;
    } ihc_int_s;

endpackage

// file: rtl/ihc_slot_pipe.sv
// Purpose: holds a self-issued command word through its delay slots
// Assumes: i_adv pulses once per instruction leaving execute
// Notes:   a new issue while one is in flight is dropped
module ihc_slot_pipe (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // issue side
    input wire ihc_pkg::ihc_cmd_s i_cmd,
    input wire logic i_stall,
    input wire logic i_adv,
    // effect side
    output ihc_pkg::ihc_cmd_s o_cmd
);

    ihc_pkg::ihc_slot_e state_reg;
    logic [ihc_pkg::SLOT_W-1:0] cnt_reg;
    logic [ihc_pkg::WORD_W-1:0] word_reg;

    // ----------------------------------------------------------------
    // slot sequencer
    // ----------------------------------------------------------------
    // the word waits out a stall in EXEC so the
    // delay slots always count the same way
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ihc_pkg::SLOT_IDLE;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                ihc_pkg::SLOT_IDLE: begin
                    if (i_cmd.valid) begin
                        state_reg <= ihc_pkg::SLOT_EXEC;
                    end
                end
                ihc_pkg::SLOT_EXEC: begin
                    if (!i_stall) begin
                        state_reg <= ihc_pkg::SLOT_WAIT;
                        cnt_reg <= '0;
                    end
                end
                ihc_pkg::SLOT_WAIT: begin
                    if (i_adv && !i_stall) begin
                        cnt_reg <= cnt_reg + 1'b1;
                        if (cnt_reg + 1'b1 == ihc_pkg::DELAY_SLOTS) begin
                            state_reg <= ihc_pkg::SLOT_IDLE;
                        end
                    end
                end
                default: state_reg <= ihc_pkg::SLOT_IDLE;
            endcase
        end
    end

    // word capture and one-cycle effect strobe
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            word_reg <= '0;
            o_cmd <= '0;
        end else begin
            if (state_reg == ihc_pkg::SLOT_IDLE && i_cmd.valid) begin
                word_reg <= i_cmd.word;
            end
            o_cmd.valid <= state_reg == ihc_pkg::SLOT_WAIT && i_adv && !i_stall
                && cnt_reg + 1'b1 == ihc_pkg::DELAY_SLOTS;
            o_cmd.word <= word_reg;
        end
    end

endmodule

// file: rtl/ihc_handler.sv
// Purpose: interprocessor command handler of one parallel cpu
// Assumes: all inputs synchronous to i_clk; CPU_ID fixed per instance
// Notes:   owns the halt latch, interrupt flags and cache-clear strobe
//
// Contract
// - act only when own designator bit set
// - own halt and cache reset target self only
// - master-only bits from parallel cpus ignored
// - peer halt or cache reset ignored here
// - accepted halt sets latch, stalls pipeline
// - interrupts latched, not serviced while halted
// - stay halted until master unhalts
// - master unhalt beats same-cycle self halt
// - halt latch visible to master status
// - self halt/clear needs own designator
// - master unhalt clears halt latch
// - unhalt after reset fetches task vector
// - software reset always leaves target halted
// - halt plus unhalt word acts as unhalt
// - cache reset clears all present bits
// - task bit from master only sets flag
// - message bit sets flag of designated cpus
// - master-designated message flags sender at master
// - peer message sets per-sender flag
// - master designators pick responding cpus
// - own command acts after two delay slots
// - stalled execute holds command back
module ihc_handler #(
    parameter int CPU_ID = 0,
    // command word layout
    parameter int P_DES_LSB = ihc_pkg::BIT_DES_LSB,
    parameter int P_DES_MST = ihc_pkg::BIT_DES_MST,
    parameter int P_RST = ihc_pkg::BIT_RST,
    parameter int P_HALT = ihc_pkg::BIT_HALT,
    parameter int P_UNHALT = ihc_pkg::BIT_UNHALT,
    parameter int P_ICLR = ihc_pkg::BIT_ICLR,
    parameter int P_TASK = ihc_pkg::BIT_TASK,
    parameter int P_MSG = ihc_pkg::BIT_MSG,
    parameter int P_DCLR = ihc_pkg::BIT_DCLR,
    parameter int P_VIDEO = ihc_pkg::BIT_VIDEO,
    parameter int P_XFER = ihc_pkg::BIT_XFER
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // commands from master_cpu and from the other parallel_cpus
    input wire ihc_pkg::ihc_cmd_s i_mst_cmd,
    input wire ihc_pkg::ihc_cmd_s [ihc_pkg::NUM_CPU-1:0] i_peer_cmd,
    // own issue through the command pseudoregister
    input wire ihc_pkg::ihc_cmd_s i_own_cmd,
    input wire logic i_pipe_stall,
    input wire logic i_instr_adv,
    // interrupt enables and flag clears from software
    input wire logic i_int_global_en,
    input wire logic i_task_en,
    input wire logic i_msg_en,
    input wire logic i_task_clr,
    input wire logic i_mst_msg_clr,
    input wire logic [ihc_pkg::NUM_CPU-1:0] i_peer_msg_clr,
    // core control
    output logic o_halted,
    output logic o_master_cpu_error_status_halt,
    output logic o_icache_clr,
    output logic o_soft_reset,
    output logic o_fetch_vector,
    // interrupt flags and requests
    output logic o_task_flag,
    output logic o_mst_msg_flag,
    output logic [ihc_pkg::NUM_CPU-1:0] o_peer_msg_flag,
    output ihc_pkg::ihc_int_s o_int_req,
    // outgoing command from this cpu
    output ihc_pkg::ihc_cmd_s o_out_cmd,
    output logic o_mst_msg_set
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // one bit of a word at a parameter position
    function automatic logic bit_at(input logic [ihc_pkg::WORD_W-1:0] w,
                                    input int pos);
        bit_at = w[pos];
    endfunction

    // word designates this parallel cpu
    function automatic logic for_me(input logic [ihc_pkg::WORD_W-1:0] w);
        for_me = w[P_DES_LSB + CPU_ID];
    endfunction

    // ----------------------------------------------------------------
    // delay slots of self-issued commands
    // ----------------------------------------------------------------
    ihc_pkg::ihc_cmd_s own_fire;

    ihc_slot_pipe u_slot (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_cmd(i_own_cmd),
        .i_stall(i_pipe_stall),
        .i_adv(i_instr_adv),
        .o_cmd(own_fire)
    );

    // ----------------------------------------------------------------
    // decode of master words
    // ----------------------------------------------------------------
    logic mst_hit;
    logic mst_rst;
    logic mst_halt;
    logic mst_unhalt;
    logic mst_iclr;
    logic mst_task;
    logic mst_msg;

    // master designators select who responds
    assign mst_hit = i_mst_cmd.valid && for_me(i_mst_cmd.word);
    assign mst_rst = mst_hit && bit_at(i_mst_cmd.word, P_RST);
    // halt and unhalt together act as unhalt
    assign mst_unhalt = mst_hit && bit_at(i_mst_cmd.word, P_UNHALT);
    assign mst_halt = mst_hit && bit_at(i_mst_cmd.word, P_HALT)
        && !mst_unhalt;
    assign mst_iclr = mst_hit && bit_at(i_mst_cmd.word, P_ICLR);
    assign mst_task = mst_hit && bit_at(i_mst_cmd.word, P_TASK);
    assign mst_msg = mst_hit && bit_at(i_mst_cmd.word, P_MSG);

    // ----------------------------------------------------------------
    // decode of own words after their delay slots
    // ----------------------------------------------------------------
    logic own_hit;
    logic own_halt;
    logic own_iclr;
    logic own_msg;

    // from self only halt, cache reset and message count;
    // master-only bits are never looked at
    assign own_hit = own_fire.valid && for_me(own_fire.word);
    assign own_halt = own_hit && bit_at(own_fire.word, P_HALT);
    assign own_iclr = own_hit && bit_at(own_fire.word, P_ICLR);
    assign own_msg = own_hit && bit_at(own_fire.word, P_MSG);

    // ----------------------------------------------------------------
    // decode of peer words
    // ----------------------------------------------------------------
    // a peer may only send messages; all else in its
    // word is dropped here
    logic [ihc_pkg::NUM_CPU-1:0] peer_msg;

    genvar g;
    generate
        for (g = 0; g < ihc_pkg::NUM_CPU; g++) begin : g_peer
            if (g == CPU_ID) begin : g_self
                assign peer_msg[g] = own_msg; // own slot comes from the pipe
            end else begin : g_other
                assign peer_msg[g] = i_peer_cmd[g].valid
                    && for_me(i_peer_cmd[g].word)
                    && bit_at(i_peer_cmd[g].word, P_MSG);
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // halt latch
    // ----------------------------------------------------------------
    logic halt_reg;
    logic halt_next;
    logic vec_pend_reg;

    // priority: software reset, then unhalt, then any halt
    always_comb begin
        halt_next = halt_reg;
        if (mst_rst) begin
            halt_next = 1'b1;
        end else if (mst_unhalt) begin
            halt_next = 1'b0;
        end else if (mst_halt || own_halt) begin
            halt_next = 1'b1;
        end
    end

    // only a master unhalt ever clears the latch
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            halt_reg <= ihc_pkg::HALT_RST;
        end else begin
            halt_reg <= halt_next;
        end
    end

    // remembers that the current halt came from a reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            vec_pend_reg <= ihc_pkg::VEC_PEND_RST;
        end else if (mst_rst) begin
            vec_pend_reg <= 1'b1;
        end else if (mst_unhalt && halt_reg) begin
            vec_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // core strobes
    // ----------------------------------------------------------------
    // one-cycle strobes, one clock after the command
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_icache_clr <= 1'b0;
            o_soft_reset <= 1'b0;
            o_fetch_vector <= 1'b0;
        end else begin
            o_icache_clr <= mst_iclr || own_iclr;
            o_soft_reset <= mst_rst;
            // a plain halt resumes in place; a reset halt restarts
            o_fetch_vector <= mst_unhalt && !mst_rst && halt_reg
                && vec_pend_reg;
        end
    end

    // latch copies for pipeline and master status
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_halted <= ihc_pkg::HALT_RST;
            o_master_cpu_error_status_halt <= ihc_pkg::HALT_RST;
        end else begin
            o_halted <= halt_next;
            o_master_cpu_error_status_halt <= halt_next;
        end
    end

    // ----------------------------------------------------------------
    // interrupt flags
    // ----------------------------------------------------------------
    // set beats clear, so no event is lost
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_task_flag <= 1'b0;
            o_mst_msg_flag <= 1'b0;
        end else begin
            o_task_flag <= mst_task || (o_task_flag && !i_task_clr);
            o_mst_msg_flag <= mst_msg
                || (o_mst_msg_flag && !i_mst_msg_clr);
        end
    end

    // one flag per sending parallel cpu
    generate
        for (g = 0; g < ihc_pkg::NUM_CPU; g++) begin : g_flag
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    o_peer_msg_flag[g] <= 1'b0;
                end else begin
                    o_peer_msg_flag[g] <= peer_msg[g]
                        || (o_peer_msg_flag[g] && !i_peer_msg_clr[g]);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupt requests
    // ----------------------------------------------------------------
    // one request at a time: task, master message, then peers by
    // sender number; flags keep latching while halted, but nothing
    // is requested before the unhalt
    logic [ihc_pkg::NUM_CPU-1:0] peer_pick;
    logic any_req;
    logic task_go;
    logic mst_go;

    assign any_req = !halt_next && i_int_global_en;
    assign task_go = any_req && i_task_en && o_task_flag;
    assign mst_go = any_req && i_msg_en && o_mst_msg_flag && !task_go;

    always_comb begin
        peer_pick = '0;
        for (int i = ihc_pkg::NUM_CPU - 1; i >= 0; i--) begin
            if (o_peer_msg_flag[i]) begin
                peer_pick = '0;
                peer_pick[i] = 1'b1;
            end
        end
        if (!(any_req && i_msg_en) || task_go || mst_go) begin
            peer_pick = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_int_req <= '0;
        end else begin
            o_int_req.task_req <= task_go;
            o_int_req.mst_msg_req <= mst_go;
            o_int_req.peer_msg_req <= peer_pick;
        end
    end

    // ----------------------------------------------------------------
    // outgoing command
    // ----------------------------------------------------------------
    // master-only bits are stripped before the word leaves, so no
    // receiver acts on them
    logic [ihc_pkg::WORD_W-1:0] strip_mask;

    always_comb begin
        strip_mask = '1;
        strip_mask[P_RST] = 1'b0;
        strip_mask[P_UNHALT] = 1'b0;
        strip_mask[P_TASK] = 1'b0;
        strip_mask[P_DCLR] = 1'b0;
        strip_mask[P_VIDEO] = 1'b0;
        strip_mask[P_XFER] = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_out_cmd <= '0;
            o_mst_msg_set <= 1'b0;
        end else begin
            o_out_cmd.valid <= own_fire.valid;
            o_out_cmd.word <= own_fire.word & strip_mask;
            // master designator plus message flags the sender
            o_mst_msg_set <= own_fire.valid
                && bit_at(own_fire.word, P_DES_MST)
                && bit_at(own_fire.word, P_MSG);
        end
    end

endmodule

// file: tb/ihc_handler_asserts.sv
// Purpose: port checks of the command handler
// Assumes: package default bit positions
// Notes:   bound into every handler instance
module ihc_handler_asserts #(
    parameter int CPU_ID = 0
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // incoming words
    input wire ihc_pkg::ihc_cmd_s i_mst_cmd,
    input wire ihc_pkg::ihc_cmd_s [ihc_pkg::NUM_CPU-1:0] i_peer_cmd,
    // watched outputs
    input wire logic o_halted,
    input wire logic o_master_cpu_error_status_halt,
    input wire logic o_icache_clr,
    input wire logic o_soft_reset,
    input wire logic o_fetch_vector,
    input wire logic o_task_flag,
    input wire logic [ihc_pkg::NUM_CPU-1:0] o_peer_msg_flag,
    input wire ihc_pkg::ihc_int_s o_int_req,
    input wire ihc_pkg::ihc_cmd_s o_out_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DES = ihc_pkg::BIT_DES_LSB + CPU_ID;
    localparam logic [31:0] MST_ONLY = (32'h1 << ihc_pkg::BIT_RST)
        | (32'h1 << ihc_pkg::BIT_UNHALT) | (32'h1 << ihc_pkg::BIT_TASK)
        | (32'h1 << ihc_pkg::BIT_DCLR) | (32'h1 << ihc_pkg::BIT_VIDEO)
        | (32'h1 << ihc_pkg::BIT_XFER);
    logic acc, m_r, m_u, m_h;
    logic [ihc_pkg::NUM_CPU-1:0] p_hit;
    // master decode, reset > unhalt > halt
    assign acc = i_mst_cmd.valid && i_mst_cmd.word[DES];
    assign m_r = acc && i_mst_cmd.word[ihc_pkg::BIT_RST];
    assign m_u = acc && i_mst_cmd.word[ihc_pkg::BIT_UNHALT] && !m_r;
    assign m_h = acc && i_mst_cmd.word[ihc_pkg::BIT_HALT] && !m_r && !m_u;
    // peer message hits; own slot never counts
    always_comb begin
        for (int g = 0; g < ihc_pkg::NUM_CPU; g++) begin
            p_hit[g] = i_peer_cmd[g].valid && i_peer_cmd[g].word[DES]
                && i_peer_cmd[g].word[ihc_pkg::BIT_MSG] && g != CPU_ID;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    AST_MST_HALT: assert property (m_h |=> o_halted)
        else $error("halt not latched");
    AST_MST_UNHALT: assert property (m_u |=> !o_halted)
        else $error("unhalt not cleared");
    AST_SOFT_RESET: assert property (m_r |=> o_halted && o_soft_reset)
        else $error("reset not halted");
    AST_STAY_HALTED: assert property (o_halted && !m_u |=> o_halted)
        else $error("halt dropped");
    AST_STATUS: assert property (o_master_cpu_error_status_halt == o_halted)
        else $error("status differs");
    AST_ICLR: assert property (acc && i_mst_cmd.word[ihc_pkg::BIT_ICLR] |=> o_icache_clr)
        else $error("no cache clear");
    AST_TASK: assert property (acc && i_mst_cmd.word[ihc_pkg::BIT_TASK] |=> o_task_flag)
        else $error("task flag not set");
    AST_PEER_MSG: assert property (p_hit != 0 |=> (o_peer_msg_flag & $past(p_hit)) == $past(p_hit))
        else $error("sender flag not set");
    AST_HALT_NO_SVC: assert property (o_halted |-> o_int_req == '0)
        else $error("request while halted");
    AST_VEC_CAUSE: assert property (o_fetch_vector |-> $past(m_u) && $past(o_halted))
        else $error("stray vector fetch");
    AST_STRIP: assert property (o_out_cmd.valid |-> (o_out_cmd.word & MST_ONLY) == '0)
        else $error("master-only bits sent");
    AST_OUT_PULSE: assert property (o_out_cmd.valid |=> !o_out_cmd.valid)
        else $error("outgoing valid too long");
    // main scenarios reached
    cover property (m_u && o_halted);
    cover property (o_out_cmd.valid);
    cover property (o_fetch_vector);
endmodule

bind ihc_handler ihc_handler_asserts #(.CPU_ID(CPU_ID)) u_asserts (
    .i_clk, .i_rstn, .i_mst_cmd, .i_peer_cmd, .o_halted, .o_master_cpu_error_status_halt,
    .o_icache_clr, .o_soft_reset, .o_fetch_vector, .o_task_flag, .o_peer_msg_flag,
    .o_int_req, .o_out_cmd
);

// file: tb/ihc_mst_model.sv
// Purpose: master_cpu side issuing command words
// Assumes: valid high one cycle per word
// Notes:   idle word is the inverse of the last
module ihc_mst_model (
    // clock and status
    input wire logic i_clk,
    input wire logic i_halted,
    // command to the handler
    output ihc_pkg::ihc_cmd_s o_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_cmd = '0;
    // ------------------------------------------------------------
    // word transfer
    // ------------------------------------------------------------
    task automatic send(input logic [31:0] w);
        @(posedge i_clk);
        o_cmd <= '{valid: 1'b1, word: w};
        @(posedge i_clk);
        o_cmd <= '{valid: 1'b0, word: ~w};
    endtask
    // cache clear, then unhalt once status shows halted
    task automatic start(input logic [31:0] des);
        int n;
        send(des | (32'h1 << ihc_pkg::BIT_ICLR));
        n = 0;
        while (i_halted !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        send(des | (32'h1 << ihc_pkg::BIT_UNHALT));
    endtask
endmodule

// file: tb/ihc_handler_tb.sv
// Purpose: self-checking bench of the command handler, cpu 0
// Assumes: default bit positions; task and message enables held on
// Notes:   outputs sampled 1 ns after the edge
module ihc_handler_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // D own designator; X data-cache, video and transfer bits
    localparam logic [31:0] D = 32'h1, H = D << ihc_pkg::BIT_HALT, U = D << ihc_pkg::BIT_UNHALT,
        R = D << ihc_pkg::BIT_RST, I = D << ihc_pkg::BIT_ICLR, K = D << ihc_pkg::BIT_TASK,
        G = D << ihc_pkg::BIT_MSG, M = D << ihc_pkg::BIT_DES_MST, X = 32'h01C00000;
    logic i_clk, i_rstn, stall, adv, task_clr, ien;
    logic halted, st_halt, iclr, srst, vec, task_f, mmsg_f, mmsg_set;
    logic [ihc_pkg::NUM_CPU-1:0] pmsg_f;
    ihc_pkg::ihc_cmd_s own_cmd, mst_cmd, out_cmd;
    ihc_pkg::ihc_cmd_s [ihc_pkg::NUM_CPU-1:0] peer_cmd;
    ihc_pkg::ihc_int_s int_req;
    int n_mismatch = 0;
    int check_count = 0;
    ihc_mst_model mst (.i_clk(i_clk), .i_halted(st_halt), .o_cmd(mst_cmd));
    ihc_handler #(.CPU_ID(0)) uut (
        .i_clk, .i_rstn, .i_mst_cmd(mst_cmd), .i_peer_cmd(peer_cmd),
        .i_own_cmd(own_cmd), .i_pipe_stall(stall), .i_instr_adv(adv),
        .i_int_global_en(ien), .i_task_en(1'b1), .i_msg_en(1'b1),
        .i_task_clr(task_clr), .i_mst_msg_clr(1'b0), .i_peer_msg_clr(4'h0),
        .o_halted(halted), .o_master_cpu_error_status_halt(st_halt),
        .o_icache_clr(iclr), .o_soft_reset(srst), .o_fetch_vector(vec),
        .o_task_flag(task_f), .o_mst_msg_flag(mmsg_f), .o_peer_msg_flag(pmsg_f),
        .o_int_req(int_req), .o_out_cmd(out_cmd), .o_mst_msg_set(mmsg_set)
    );
    // 10 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic nxt;
        @(posedge i_clk);
        #1;
    endtask
    // own issue; adv pulses during a stall must not count
    task automatic own_issue(input logic [31:0] w, input int nst);
        int cw;
        cw = (nst == 0) ? 2 : nst + 1;
        @(posedge i_clk);
        own_cmd <= '{valid: 1'b1, word: w};
        stall <= nst > 0;
        adv <= nst > 0;
        for (int i = 1; i <= cw + 1; i++) begin
            @(posedge i_clk);
            own_cmd <= '{valid: 1'b0, word: ~w};
            stall <= i < nst;
            adv <= i >= cw || i < nst;
        end
        @(posedge i_clk);
        adv <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        #1;
        chk("halted", halted, 1);
        chk("status", st_halt, 1);
        mst.send(R | H | U | I | K | G | 32'hE);
        #1;
        chk("foreign halted", halted, 1);
        chk("foreign iclr", iclr, 0);
        chk("foreign reset", srst, 0);
        chk("foreign task", task_f, 0);
        mst.start(D);
        #1;
        chk("start vector", vec, 1);
        chk("start halted", halted, 0);
        $display("done: reset and start");
    endtask
    task automatic t_halt;
        mst.send(H | D);
        nxt;
        chk("halt", halted, 1);
        mst.send(K | D);
        nxt;
        chk("task flag", task_f, 1);
        chk("task held", int_req.task_req, 0);
        chk("still halted", halted, 1);
        mst.send(H | U | D);
        #1;
        chk("h+u", halted, 0);
        chk("no vector", vec, 0);
        @(posedge i_clk);
        task_clr <= 1'b1;
        ien <= 1'b0;
        #1;
        chk("task taken", int_req.task_req, 1);
        @(posedge i_clk);
        task_clr <= 1'b0;
        ien <= 1'b1;
        #1;
        chk("task cleared", task_f, 0);
        chk("task gated", int_req.task_req, 0);
        $display("done: halt");
    endtask
    task automatic t_own;
        own_issue(H | 32'h2, 0);
        nxt;
        chk("self halt no des", halted, 0);
        own_issue(I | D, 3);
        #1;
        chk("iclr held", iclr, 0);
        nxt;
        chk("own iclr", iclr, 1);
        own_issue(H | D | R | U | K | X, 0);
        #1;
        chk("slot halted", halted, 0);
        nxt;
        chk("own halt", halted, 1);
        chk("out word", out_cmd.word, H | D);
        mst.send(U | D);
        #1;
        chk("unhalt", halted, 0);
        chk("resume no vector", vec, 0);
        own_issue(G | M | D, 0);
        nxt;
        chk("master msg set", mmsg_set, 1);
        chk("self msg", pmsg_f[0], 1);
        $display("done: own");
    endtask
    task automatic t_peer;
        @(posedge i_clk);
        peer_cmd[1] <= '{valid: 1'b1, word: H | I | G | D};
        @(posedge i_clk);
        peer_cmd[1] <= '{valid: 1'b0, word: ~(H | I | G | D)};
        #1;
        chk("peer msg", pmsg_f[1], 1);
        chk("peer halt", halted, 0);
        chk("peer iclr", iclr, 0);
        mst.send(G | D);
        nxt;
        chk("master msg", mmsg_f, 1);
        $display("done: peer");
    endtask
    // self halt and master unhalt meet in one cycle
    task automatic t_race;
        fork
            own_issue(H | D, 0);
            begin
                repeat (4) @(posedge i_clk);
                mst.send(U | D);
            end
        join
        #1;
        chk("race", halted, 0);
        mst.send(R | U | D);
        #1;
        chk("reset halted", halted, 1);
        chk("reset pulse", srst, 1);
        mst.start(D);
        #1;
        chk("reset vector", vec, 1);
        $display("done: race and reset");
    endtask
    // ------------------------------------------------------------
    // verdict, main sequence, watchdog
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        i_rstn = 1'b0;
        stall = 1'b0;
        adv = 1'b0;
        task_clr = 1'b0;
        ien = 1'b1;
        own_cmd = '0;
        peer_cmd = '0;
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_reset();
        t_halt();
        t_own();
        t_peer();
        t_race();
        print_verdict();
    end
    // run needs under a hundred cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
